// ### cevh_checker.sv
// Port checker of the event handler: event lines and register bus handshake
// Assumes it is bound into cevh_event_handler, a single clock domain
`timescale 1ns/10ps
module cevh_checker (
  input wire logic                 sys_clk_i,              // System clock
  input wire logic                 rst_b_i,                // Reset, active low
  input wire logic [7:0]           event_src_i,            // Event sources
  input wire logic                 core_event_line_zero_o, // High group line
  input wire logic                 core_event_line_one_o,  // Low group line
  input wire logic                 s_axi_awvalid_i,        // Write address valid
  input wire logic                 s_axi_awready_o,        // Write address ready
  input wire logic                 s_axi_wvalid_i,         // Write data valid
  input wire logic                 s_axi_wready_o,         // Write data ready
  input wire logic                 s_axi_bvalid_o,         // Write response valid
  input wire logic                 s_axi_arvalid_i,        // Read address valid
  input wire logic                 s_axi_arready_o,        // Read address ready
  input wire logic                 s_axi_rvalid_o,         // Read data valid
  input wire cevh_pkg::cevh_word_t s_axi_rdata_o           // Read data
);
  import cevh_pkg::*;
  logic [7:0] prev_src;
  logic       wr_any;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Write address or write data handshake at this edge
  assign wr_any = (s_axi_awvalid_i && s_axi_awready_o) || (s_axi_wvalid_i && s_axi_wready_o);
  // Previous source sample, for rise detection
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) prev_src <= 8'h00;
    else prev_src <= event_src_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  a_high_hold: assert property (core_event_line_zero_o && !wr_any |=> core_event_line_zero_o)
    else $error("high line dropped without a write");
  a_low_hold: assert property (core_event_line_one_o && !wr_any |=> core_event_line_one_o)
    else $error("low line dropped without a write");
  a_high_cause: assert property (
    $rose(core_event_line_zero_o) |-> $past(event_src_i[7:4] & ~prev_src[7:4]) != 4'h0)
    else $error("high line rose without a source rise");
  a_low_cause: assert property (
    $rose(core_event_line_one_o) |-> $past(event_src_i[3:0] & ~prev_src[3:0]) != 4'h0)
    else $error("low line rose without a source rise");
  a_write_answer: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |=> s_axi_bvalid_o)
    else $error("write response late");
  a_write_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  a_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while data pending");
  a_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
endmodule // cevh_checker

bind cevh_event_handler cevh_checker u_chk (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .event_src_i(event_src_i),
  .core_event_line_zero_o(core_event_line_zero_o), .core_event_line_one_o(core_event_line_one_o),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rdata_o(s_axi_rdata_o));

// ### cevh_core_model.sv
// Behavioural model of the processor core event inputs: halt and jump on event
// Assumes the two event lines are level signals in the system clock domain
`timescale 1ns/10ps
module cevh_core_model (
  input  wire logic sys_clk_i, // System clock
  input  wire logic rst_b_i,   // Reset, active low
  input  wire logic ev_high_i, // High group event line
  input  wire logic ev_low_i,  // Low group event line
  input  wire logic halt_i,    // Halt instruction executed
  input  wire logic jev_i,     // Jump on event instruction executed
  output logic      halted_o,  // Core is halted
  output logic      jump_o     // Jump on event is taken
);
  // Any event wakes the core; the program counter is left alone
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) halted_o <= 1'b0;
    else if (ev_high_i || ev_low_i) halted_o <= 1'b0;
    else if (halt_i) halted_o <= 1'b1;
  end
  // Jump only while an event is pending
  assign jump_o = jev_i && (ev_high_i || ev_low_i);
endmodule // cevh_core_model

// ### cevh_defines.svh
// Constants of the CPU event handler: offsets, field positions, reset values
// Assumes inclusion by bare name from the package and the design files
`ifndef CEVH_DEFINES_SVH
`define CEVH_DEFINES_SVH

// Register byte addresses
`define CEVH_OFS_FLAGS    8'h00
`define CEVH_OFS_ENABLE   8'h04
`define CEVH_OFS_TOP      8'h08
`define CEVH_OFS_SUMMARY  8'h0C
`define CEVH_OFS_IRQ_MASK 8'h10
`define CEVH_OFS_IRQ_STATUS 8'h1C

// Field positions of the level summary
`define CEVH_SUM_LOW_BIT  0
`define CEVH_SUM_HIGH_BIT 1

// Reset values
`define CEVH_RST_FLAGS    8'h00
`define CEVH_RST_ENABLE   8'h00
`define CEVH_RST_TOP      8'hFF
`define CEVH_RST_SUMMARY  8'h00
`define CEVH_RST_IRQ_MASK 8'h00
`define CEVH_RST_IRQ_STATUS 8'h00
`define CEVH_TOP_NONE     8'hFF

// Bus responses
`define CEVH_RESP_OKAY    2'h0
`define CEVH_RESP_SLVERR  2'h2

`endif

// ### cevh_event_handler.sv
// CPU event handler: eight edge latched event flags, two core event lines,
// AXI4-Lite register slave and one level interrupt
// Assumes sources synchronous to sys_clk_i, the fastest clock of the system
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "cevh_defines.svh"

module cevh_event_handler #(
  parameter int ADDR_W = 8                     // Byte address width
) (
  input  wire logic                  sys_clk_i,         // System clock, 10 MHz
  input  wire logic                  rst_b_i,           // Global reset, active low
  input  wire logic [7:0]            event_src_i,       // Event sources
  output logic                       core_event_line_zero_o, // High group event line
  output logic                       core_event_line_one_o,  // Low group event line
  output logic                       irq_o,             // Level interrupt
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_i,    // Write address
  input  wire logic                  s_axi_awvalid_i,   // Write address valid
  output logic                       s_axi_awready_o,   // Write address ready
  input  wire cevh_pkg::cevh_word_t  s_axi_wdata_i,     // Write data
  input  wire logic [3:0]            s_axi_wstrb_i,     // Write strobes
  input  wire logic                  s_axi_wvalid_i,    // Write data valid
  output logic                       s_axi_wready_o,    // Write data ready
  output cevh_pkg::cevh_resp_t       s_axi_bresp_o,     // Write response
  output logic                       s_axi_bvalid_o,    // Write response valid
  input  wire logic                  s_axi_bready_i,    // Write response ready
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_i,    // Read address
  input  wire logic                  s_axi_arvalid_i,   // Read address valid
  output logic                       s_axi_arready_o,   // Read address ready
  output cevh_pkg::cevh_word_t       s_axi_rdata_o,     // Read data
  output cevh_pkg::cevh_resp_t       s_axi_rresp_o,     // Read response
  output logic                       s_axi_rvalid_o,    // Read data valid
  input  wire logic                  s_axi_rready_i     // Read data ready
);
  import cevh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  cevh_byte_t      src_prev;        // Previous sample of the sources
  cevh_byte_t      event_flags;     // Latched event flags
  cevh_byte_t      event_enable_mask;
  cevh_byte_t      event_top_code;
  cevh_byte_t      event_level_summary;
  cevh_byte_t      irq_mask;
  cevh_byte_t      irq_status;      // Sticky event status for the interrupt
  cevh_byte_t      rise;
  cevh_byte_t      next_flags;
  cevh_byte_t      next_irq_status;
  cevh_byte_t      next_irq_mask;   // Interrupt mask as it stands after this edge
  cevh_byte_t      next_top_code;
  cevh_byte_t      flag_clear;
  cevh_byte_t      irq_clear;
  cevh_byte_t      next_summary;
  logic            high_group_pending;
  logic            low_group_pending;

  cevh_wr_state_t  wr_state;
  cevh_rd_state_t  rd_state;
  logic            aw_held;
  logic            w_held;
  logic [ADDR_W-1:0] aw_addr;
  cevh_word_t      w_data;
  logic [3:0]      w_strb;
  logic            wr_fire;
  logic            wr_hit;
  logic [ADDR_W-1:0] wr_addr_now;
  cevh_word_t      wr_data_now;
  logic [3:0]      wr_strb_now;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and flag update

  // Sample every source each system clock
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_prev <= 8'h00;
    end else begin
      src_prev <= event_src_i;
    end
  end

  // Enabled rising edges, each source on its own
  assign rise = event_src_i & ~src_prev & event_enable_mask;

  // Clears from a write that hits the flag register or the interrupt status register
  assign flag_clear = (wr_fire && wr_hit && wr_addr_now == `CEVH_OFS_FLAGS && wr_strb_now[0])
                      ? wr_data_now[7:0] : 8'h00;
  assign irq_clear  = (wr_fire && wr_hit && wr_addr_now == `CEVH_OFS_IRQ_STATUS
                       && wr_strb_now[0]) ? wr_data_now[7:0] : 8'h00;

  // Set wins over a clear in the same cycle
  assign next_flags      = (event_flags & ~flag_clear) | rise;
  assign next_irq_status = (irq_status & ~irq_clear) | rise;

  // Mask seen by the interrupt line, so a mask write acts at once
  assign next_irq_mask = (wr_fire && wr_strb_now[0] && wr_addr_now == `CEVH_OFS_IRQ_MASK)
                         ? wr_data_now[7:0] : irq_mask;

  // Latched flags
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      event_flags <= `CEVH_RST_FLAGS;
    end else begin
      event_flags <= next_flags;
    end
  end

  // Interrupt status
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= `CEVH_RST_IRQ_STATUS;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived status

  // Group summaries from the next flags so they track the flags exactly
  assign high_group_pending = |next_flags[7:4];
  assign low_group_pending  = |next_flags[3:0];

  always_comb begin
    next_summary = 8'h00;
    next_summary[`CEVH_SUM_HIGH_BIT] = high_group_pending;
    next_summary[`CEVH_SUM_LOW_BIT]  = low_group_pending;
  end

  // Highest set position wins
  always_comb begin
    next_top_code = `CEVH_TOP_NONE;
    for (int i = 0; i < 8; i++) begin
      if (next_flags[i]) begin
        next_top_code = 8'(i);
      end
    end
  end

  // Registered status, core lines and interrupt
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      event_top_code         <= `CEVH_RST_TOP;
      event_level_summary    <= `CEVH_RST_SUMMARY;
      core_event_line_zero_o <= 1'b0;
      core_event_line_one_o  <= 1'b0;
      irq_o                  <= 1'b0;
    end else begin
      event_top_code         <= next_top_code;
      event_level_summary    <= next_summary;
      core_event_line_zero_o <= high_group_pending;
      core_event_line_one_o  <= low_group_pending;
      irq_o                  <= |(next_irq_status & next_irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software writable registers

  assign wr_addr_now = aw_held ? aw_addr : s_axi_awaddr_i;
  assign wr_data_now = w_held ? w_data : s_axi_wdata_i;
  assign wr_strb_now = w_held ? w_strb : s_axi_wstrb_i;
  assign wr_hit = (wr_addr_now == `CEVH_OFS_FLAGS) || (wr_addr_now == `CEVH_OFS_ENABLE)
                  || (wr_addr_now == `CEVH_OFS_IRQ_MASK) || (wr_addr_now == `CEVH_OFS_TOP)
                  || (wr_addr_now == `CEVH_OFS_SUMMARY) || (wr_addr_now == `CEVH_OFS_IRQ_STATUS);
  // Write happens when both address and data are present in idle
  assign wr_fire = (wr_state == CEVH_WR_IDLE)
                   && (aw_held || s_axi_awvalid_i) && (w_held || s_axi_wvalid_i);

  // Enable mask and interrupt mask
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      event_enable_mask <= `CEVH_RST_ENABLE;
      irq_mask          <= `CEVH_RST_IRQ_MASK;
    end else if (wr_fire && wr_strb_now[0]) begin
      if (wr_addr_now == `CEVH_OFS_ENABLE) begin
        event_enable_mask <= wr_data_now[7:0];
      end else if (wr_addr_now == `CEVH_OFS_IRQ_MASK) begin
        irq_mask <= wr_data_now[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_state        <= CEVH_WR_IDLE;
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= '0;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `CEVH_RESP_OKAY;
    end else begin
      case (wr_state)
        CEVH_WR_IDLE: begin
          if (wr_fire) begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b1;
            s_axi_bresp_o   <= wr_hit ? `CEVH_RESP_OKAY : `CEVH_RESP_SLVERR;
            wr_state        <= CEVH_WR_RESP;
          end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
              aw_held         <= 1'b1;
              aw_addr         <= s_axi_awaddr_i;
              s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
              w_held         <= 1'b1;
              w_data         <= s_axi_wdata_i;
              w_strb         <= s_axi_wstrb_i;
              s_axi_wready_o <= 1'b0;
            end
          end
        end
        CEVH_WR_RESP: begin
          if (s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            wr_state        <= CEVH_WR_IDLE;
          end
        end
        default: begin
          wr_state <= CEVH_WR_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_state        <= CEVH_RD_IDLE;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `CEVH_RESP_OKAY;
    end else begin
      case (rd_state)
        CEVH_RD_IDLE: begin
          if (s_axi_arvalid_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rresp_o   <= `CEVH_RESP_OKAY;
            rd_state        <= CEVH_RD_DATA;
            // Address decode, unmapped gives zero data and an error
            if (s_axi_araddr_i == `CEVH_OFS_FLAGS) begin
              s_axi_rdata_o <= {24'h000000, event_flags};
            end else if (s_axi_araddr_i == `CEVH_OFS_ENABLE) begin
              s_axi_rdata_o <= {24'h000000, event_enable_mask};
            end else if (s_axi_araddr_i == `CEVH_OFS_TOP) begin
              s_axi_rdata_o <= {24'h000000, event_top_code};
            end else if (s_axi_araddr_i == `CEVH_OFS_SUMMARY) begin
              s_axi_rdata_o <= {24'h000000, event_level_summary};
            end else if (s_axi_araddr_i == `CEVH_OFS_IRQ_MASK) begin
              s_axi_rdata_o <= {24'h000000, irq_mask};
            end else if (s_axi_araddr_i == `CEVH_OFS_IRQ_STATUS) begin
              s_axi_rdata_o <= {24'h000000, irq_status};
            end else begin
              s_axi_rdata_o <= 32'h0000_0000;
              s_axi_rresp_o <= `CEVH_RESP_SLVERR;
            end
          end
        end
        CEVH_RD_DATA: begin
          if (s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
            rd_state        <= CEVH_RD_IDLE;
          end
        end
        default: begin
          rd_state <= CEVH_RD_IDLE;
        end
      endcase
    end
  end

endmodule // cevh_event_handler

// ### cevh_pkg.sv
// Types shared by the CPU event handler
// Assumes the defines header sits in the same folder
package cevh_pkg;
  `include "cevh_defines.svh"

  typedef logic [31:0] cevh_word_t;
  typedef logic [7:0]  cevh_byte_t;
  typedef logic [1:0]  cevh_resp_t;

  // Write channel handshake states
  typedef enum logic [1:0] {
    CEVH_WR_IDLE = 2'b01,
    CEVH_WR_RESP = 2'b10
  } cevh_wr_state_t;

  // Read channel handshake states
  typedef enum logic [1:0] {
    CEVH_RD_IDLE = 2'b01,
    CEVH_RD_DATA = 2'b10
  } cevh_rd_state_t;
endpackage

// ### test_cpu_event_handler.sv
// Self-checking bench of the event handler against an integer reference model
// Assumes the package, the checker and the core model are compiled first
`timescale 1ns/10ps
`include "cevh_defines.svh"
module test_cpu_event_handler;
  import cevh_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic [7:0] src = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  cevh_word_t wdata = '0, rdata, d;
  logic       awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic       halt = 1'b0, jump_on_event_instr = 1'b0, line0, line1, irq, halted, jump;
  logic [3:0] wstrb = 4'hF;
  logic       awready, wready, bvalid, arready, rvalid;
  cevh_resp_t bresp, rresp, r;
  int         err_count = 0, checked = 0, m_flags, m_en, m_mask, m_ist, m_prev, rise, fc, ic;

  always #50 sys_clk_i = ~sys_clk_i;
  cevh_event_handler dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .event_src_i(src),
    .core_event_line_zero_o(line0), .core_event_line_one_o(line1), .irq_o(irq),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  cevh_core_model u_core (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ev_high_i(line0),
    .ev_low_i(line1), .halt_i(halt), .jev_i(jump_on_event_instr), .halted_o(halted), .jump_o(jump));
  //////////////////////////////////////////////////////////////////////////////
  // Reference model: enabled rises set flags and status, set wins over clear
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {m_flags, m_en, m_mask, m_ist, m_prev} = '0;
    end else begin
      rise = src & ~m_prev & m_en;
      m_prev = src;
      {fc, ic} = '0;
      if (awvalid && awready && wvalid && wready && wstrb[0]) begin
        case (awaddr)
          8'h00: fc = wdata[7:0];
          8'h04: m_en = wdata[7:0];
          8'h10: m_mask = wdata[7:0];
          8'h1C: ic = wdata[7:0];
          default: ;
        endcase
      end
      m_flags = (m_flags & ~fc) | rise;
      m_ist = (m_ist & ~ic) | rise;
    end
  end
  function automatic int expect_reg(logic [7:0] a);
    case (a)
      8'h00: return m_flags;
      8'h04: return m_en;
      8'h08: for (int i = 7; i >= 0; i--) if (m_flags[i]) return i;
      8'h0C: return {m_flags[7:4] != 0, m_flags[3:0] != 0};
      8'h10: return m_mask;
      8'h1C: return m_ist;
      default: return 0;
    endcase
    return 255;
  endfunction
  task automatic chk_word(input cevh_word_t got, input cevh_word_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: line got %b expected %b", $time, got, exp);
    end
  endtask
  // Event lines and interrupt compared every cycle
  always @(negedge sys_clk_i) begin
    if (rst_b_i) begin
      chk_bit(line0, m_flags[7:4] != 0);
      chk_bit(line1, m_flags[3:0] != 0);
      chk_bit(irq, (m_ist & m_mask) != 0);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Bus tasks: valids held until their ready is seen, responses awaited
  task automatic wr(input logic [7:0] a, input cevh_word_t v, output cevh_resp_t rs);
    bit ta, tw;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    {ta, tw} = '0;
    while (!(ta && tw)) begin
      @(negedge sys_clk_i);
      ta = ta || awready;
      tw = tw || wready;
      @(posedge sys_clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge sys_clk_i); while (!bvalid);
    rs = bresp;
    @(posedge sys_clk_i);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output cevh_word_t v, output cevh_resp_t rs);
    @(posedge sys_clk_i);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(negedge sys_clk_i); while (!arready);
    @(posedge sys_clk_i);
    arvalid <= 1'b0;
    do @(negedge sys_clk_i); while (!rvalid);
    v = rdata;
    rs = rresp;
    @(posedge sys_clk_i);
    rready <= 1'b0;
  endtask
  task automatic check_regs();
    logic [7:0] addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
    cevh_word_t v;
    cevh_resp_t rs;
    foreach (addrs[i]) begin
      rd(addrs[i], v, rs);
      chk_word(v, expect_reg(addrs[i]));
      chk_word(rs, `CEVH_RESP_OKAY);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, random traffic, halt and wake, reset in mid-run
  initial begin
    void'($urandom(32'h172F9C58));
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    check_regs();
    rd(8'h20, d, r);
    chk_word(d, 32'h0);
    chk_word(r, `CEVH_RESP_SLVERR);
    wr(8'h20, 32'hFF, r);
    chk_word(r, `CEVH_RESP_SLVERR);
    wr(8'h08, 32'h0, r);
    chk_word(r, `CEVH_RESP_OKAY);
    repeat (40) begin
      if ($urandom_range(1)) begin
        wstrb <= 4'($urandom);
        wr(8'h04, $urandom, r);
        chk_word(r, `CEVH_RESP_OKAY);
        wstrb <= 4'hF;
      end
      wr(8'h10, $urandom, r);
      repeat (4) @(posedge sys_clk_i) src <= 8'($urandom);
      @(posedge sys_clk_i);
      check_regs();
      wr(8'h00, $urandom, r);
      wr(8'h1C, $urandom, r);
    end
    @(posedge sys_clk_i) src <= 8'h00;
    wr(8'h04, 32'hFF, r);
    wr(8'h00, 32'hFF, r);
    @(posedge sys_clk_i) {halt, jump_on_event_instr} <= 2'h3;
    @(posedge sys_clk_i) halt <= 1'b0;
    @(negedge sys_clk_i) chk_bit(halted, 1'b1);
    chk_bit(jump, 1'b0);
    @(posedge sys_clk_i) src <= 8'h01;
    repeat (3) @(negedge sys_clk_i);
    chk_bit(halted, 1'b0);
    chk_bit(jump, 1'b1);
    @(posedge sys_clk_i) src <= 8'h80;
    @(posedge sys_clk_i) src <= 8'h00;
    @(posedge sys_clk_i) rst_b_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    check_regs();
    print_verdict();
  end
  // Watchdog against a hung handshake
  initial begin
    #2000000;
    err_count++;
    print_verdict();
  end
endmodule // test_cpu_event_handler
